// ### avbb_params.svh
// Purpose: Offsets, reset values, field positions and timing counts of the axis buffer/bias bank.
// Assumes: 50 MHz module clock.
// Notes: Definitions only.
`ifndef AVBB_PARAMS_SVH
`define AVBB_PARAMS_SVH

`define AVBB_ADDR_Y_BUF 7'h10
`define AVBB_ADDR_Z_BUF 7'h12
`define AVBB_ADDR_X_BIAS 7'h14
`define AVBB_ADDR_Y_BIAS 7'h16
`define AVBB_ADDR_Z_BIAS 7'h18
`define AVBB_ADDR_LAST 7'h19
`define AVBB_RESET_WORD 16'h0000
`define AVBB_SIGNED_FULL 16'h7fff
`define AVBB_SIGNED_MIN 16'h8000
`define AVBB_UNSIGNED_FULL 16'hffff
`define AVBB_SPI_WRITE_BIT 15
`define AVBB_SPI_ADDR_MSB 14
`define AVBB_SPI_ADDR_LSB 8
`define AVBB_FRAME_LAST_BIT 5'd15
`define AVBB_BUF_DEPTH 4096
`define AVBB_PNTR_W 12
`define AVBB_CLK_PERIOD_NS 20
`define AVBB_FULL_RATE_SPS 220000
`define AVBB_SAMPLE_DIV ((1000000000 / `AVBB_FULL_RATE_SPS) / `AVBB_CLK_PERIOD_NS)
`define AVBB_AUTONULL_SAMPLES 4096
`define AVBB_AUTONULL_SHIFT 12
`define AVBB_AUTONULL_TIME_MS 16
`define AVBB_RSS_STEPS 5'd16

`endif

// ### avbb_pkg.sv
// Purpose: Types shared by the axis buffer/bias bank.
// Assumes: Nothing beyond the parameter header.
// Notes: Gray codes from idle through accumulate to done; the return from done to idle flips both bits.
package avbb_pkg;
	typedef enum logic [1:0] {
		AVBB_MANUAL_SPECTRUM_MODE = 2'b00,
		AVBB_AUTOMATIC_SPECTRUM_MODE = 2'b01,
		AVBB_TIME_CAPTURE_MODE = 2'b10,
		AVBB_REAL_TIME_STREAM = 2'b11
	} avbb_mode_t;
	typedef enum logic [1:0] {
		AVBB_AN_IDLE = 2'b00,
		AVBB_AN_ACC = 2'b01,
		AVBB_AN_DONE = 2'b11
	} avbb_an_state_t;
	typedef enum logic {
		AVBB_RSS_IDLE = 1'b0,
		AVBB_RSS_RUN = 1'b1
	} avbb_rss_state_t;
endpackage

// ### avbb_rss_if.sv
// Purpose: Carries one root-sum-square job between the bank and its square-root solver.
// Assumes: Both ends share the module clock.
// Notes: start is a one-cycle pulse; done is a one-cycle pulse with root valid.
interface avbb_rss_if;
	logic start;
	logic [33:0] radicand;
	logic sat_unsigned;
	logic done;
	logic [15:0] root;
	modport requester(output start, output radicand, output sat_unsigned, input done, input root);
	modport solver(input start, input radicand, input sat_unsigned, output done, output root);
endinterface

// ### avbb_rss.sv
// Purpose: Bit-serial square root of the summed squares, saturated to the word format.
// Assumes: A new start comes only after done.
// Notes: 17 iterations; done comes 18 cycles after the start cycle.
`include "avbb_params.svh"
module avbb_rss import avbb_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	avbb_rss_if.solver rss
);
	avbb_rss_state_t state, next_state;
	logic [35:0] rem, next_rem, rem_sh, trial;
	logic [33:0] rad, next_rad;
	logic [16:0] q, next_q;
	logic [4:0] cnt, next_cnt;
	logic sat_u, next_sat_u;
	logic done_r, next_done;
	logic [15:0] root_r, next_root, limit;
	always_comb begin
		next_state = state;
		next_rem = rem;
		next_rad = rad;
		next_q = q;
		next_cnt = cnt;
		next_sat_u = sat_u;
		next_done = 1'b0;
		next_root = root_r;
		rem_sh = {rem[33:0], rad[33:32]};
		trial = {17'h00000, q, 2'b01};
		limit = sat_u ? `AVBB_UNSIGNED_FULL : `AVBB_SIGNED_FULL;
		case (state)
			AVBB_RSS_IDLE: begin
				if (rss.start) begin
					next_rad = rss.radicand;
					next_rem = 36'h0;
					next_q = 17'h0;
					next_cnt = 5'd0;
					next_sat_u = rss.sat_unsigned;
					next_state = AVBB_RSS_RUN;
				end
			end
			AVBB_RSS_RUN: begin
				if (rem_sh >= trial) begin
					next_rem = rem_sh - trial;
					next_q = {q[15:0], 1'b1};
				end else begin
					next_rem = rem_sh;
					next_q = {q[15:0], 1'b0};
				end
				next_rad = {rad[31:0], 2'b00};
				next_cnt = cnt + 5'd1;
				if (cnt == `AVBB_RSS_STEPS) begin
					// Clip at the full-scale code of the format in use.
					next_root = (next_q > {1'b0, limit}) ? limit : next_q[15:0];
					next_done = 1'b1;
					next_state = AVBB_RSS_IDLE;
				end
			end
			default: next_state = AVBB_RSS_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= AVBB_RSS_IDLE;
			rem <= 36'h0;
			rad <= 34'h0;
			q <= 17'h0;
			cnt <= 5'd0;
			sat_u <= 1'b0;
			done_r <= 1'b0;
			root_r <= 16'h0000;
		end else begin
			state <= next_state;
			rem <= next_rem;
			rad <= next_rad;
			q <= next_q;
			cnt <= next_cnt;
			sat_u <= next_sat_u;
			done_r <= next_done;
			root_r <= next_root;
		end
	end
	assign rss.done = done_r;
	assign rss.root = root_r;
endmodule

// ### avbb_top.sv
// Purpose: Y/Z buffer access words and per-axis bias correction behind the serial port.
// Assumes: Serial pins synchronous to clk; mode and enables come from recording control.
// Notes: Serial frames are 16 bits, clock idles high, data in sampled on rising edges.
`include "avbb_params.svh"
module avbb_top import avbb_pkg::*; #(
	parameter int BUF_DEPTH = `AVBB_BUF_DEPTH,
	parameter int PNTR_W = `AVBB_PNTR_W,
	parameter int AN_SAMPLES = `AVBB_AUTONULL_SAMPLES,
	parameter int AN_SHIFT = `AVBB_AUTONULL_SHIFT,
	parameter int SAMPLE_DIV = `AVBB_SAMPLE_DIV
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic cs_b,
	input wire logic din,
	output logic dout,
	input wire logic [1:0] rec_mode,
	input wire logic rss_en,
	input wire logic vel_en,
	input wire logic autonull_cmd,
	input wire logic flash_valid,
	input wire logic [15:0] flash_x_bias,
	input wire logic [15:0] flash_y_bias,
	input wire logic [15:0] flash_z_bias,
	input wire logic [15:0] raw_x,
	input wire logic [15:0] raw_y,
	input wire logic [15:0] raw_z,
	input wire logic capture_start,
	input wire logic capture_done,
	input wire logic sample_valid,
	input wire logic [15:0] accel_x,
	input wire logic [15:0] accel_y,
	input wire logic [15:0] accel_z,
	input wire logic [15:0] velocity_x,
	input wire logic [15:0] velocity_y,
	input wire logic [15:0] velocity_z,
	input wire logic [15:0] spectrum_x,
	input wire logic [15:0] spectrum_y,
	input wire logic [15:0] spectrum_z,
	input wire logic [PNTR_W-1:0] buf_pntr,
	output logic buf_advance,
	output logic [15:0] corrected_x,
	output logic [15:0] corrected_y,
	output logic [15:0] corrected_z,
	output logic autonull_busy
);
	localparam int ACC_W = 17 + AN_SHIFT;
	localparam int DIV_W = $clog2(SAMPLE_DIV + 1);
	localparam int ANC_W = $clog2(AN_SAMPLES + 1);

	function automatic logic [15:0] sat17(input logic [16:0] v);
		if (v[16] != v[15]) begin
			return v[16] ? `AVBB_SIGNED_MIN : `AVBB_SIGNED_FULL;
		end
		return v[15:0];
	endfunction
	function automatic logic [15:0] mag(input logic [15:0] v, input logic is_u);
		if (!is_u && v[15]) begin
			return 16'(~v + 16'h0001);
		end
		return v;
	endfunction

	logic [15:0] regs [0:4];
	logic [15:0] next_regs [0:4];
	logic restored, next_restored;
	logic sclk_q, cs_q, rd_pend, next_rd_pend, next_dout, next_adv;
	logic [15:0] sh_in, next_sh_in, sh_out, next_sh_out;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [6:0] rd_addr, next_rd_addr;
	logic rise, fall, frame_start, wr_strobe, word_strobe, rd_is_buf, stored_mode, fft_mode;
	logic [15:0] word, rd_value;
	logic [6:0] wr_addr, rd_off, wr_off;
	// Spectrum modes carry unsigned log-coded magnitudes; time capture carries signed counts.
	assign fft_mode = (rec_mode == AVBB_MANUAL_SPECTRUM_MODE) ||
		(rec_mode == AVBB_AUTOMATIC_SPECTRUM_MODE);
	assign stored_mode = (rec_mode != AVBB_REAL_TIME_STREAM);
	assign rise = sclk && !sclk_q && !cs_b;
	assign fall = !sclk && sclk_q && !cs_b;
	assign frame_start = !cs_b && cs_q;
	assign word = {sh_in[14:0], din};
	assign word_strobe = rise && (bit_cnt == `AVBB_FRAME_LAST_BIT);
	assign wr_strobe = word_strobe && word[`AVBB_SPI_WRITE_BIT];
	assign wr_addr = word[`AVBB_SPI_ADDR_MSB:`AVBB_SPI_ADDR_LSB];
	assign wr_off = wr_addr - `AVBB_ADDR_Y_BUF;
	assign rd_off = rd_addr - `AVBB_ADDR_Y_BUF;
	assign rd_is_buf = (rd_addr == `AVBB_ADDR_Y_BUF) || (rd_addr == `AVBB_ADDR_Z_BUF);
	always_comb begin
		rd_value = `AVBB_RESET_WORD;
		if (rd_addr >= `AVBB_ADDR_Y_BUF && rd_addr <= `AVBB_ADDR_LAST) begin
			rd_value = regs[rd_off[3:1]];
		end
	end

	// Serial frame engine.
	always_comb begin
		next_sh_in = sh_in;
		next_sh_out = sh_out;
		next_bit_cnt = bit_cnt;
		next_rd_addr = rd_addr;
		next_rd_pend = rd_pend;
		next_dout = dout;
		next_adv = 1'b0;
		if (frame_start) begin
			next_sh_out = rd_value;
			next_bit_cnt = 5'd0;
			// Delivering a whole buffer word moves the pointer on in stored modes.
			next_adv = rd_pend && rd_is_buf && stored_mode;
			next_rd_pend = 1'b0;
		end
		if (fall) begin
			next_dout = sh_out[15];
			next_sh_out = {sh_out[14:0], 1'b0};
		end
		if (rise) begin
			next_sh_in = word;
			next_bit_cnt = bit_cnt + 5'd1;
		end
		if (word_strobe && !word[`AVBB_SPI_WRITE_BIT]) begin
			next_rd_addr = {wr_addr[6:1], 1'b0};
			next_rd_pend = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sclk_q <= 1'b1;
			cs_q <= 1'b1;
			sh_in <= 16'h0000;
			sh_out <= 16'h0000;
			bit_cnt <= 5'd0;
			rd_addr <= 7'h00;
			rd_pend <= 1'b0;
			dout <= 1'b0;
			buf_advance <= 1'b0;
		end else begin
			sclk_q <= sclk;
			cs_q <= cs_b;
			sh_in <= next_sh_in;
			sh_out <= next_sh_out;
			bit_cnt <= next_bit_cnt;
			rd_addr <= next_rd_addr;
			rd_pend <= next_rd_pend;
			dout <= next_dout;
			buf_advance <= next_adv;
		end
	end

	// Capture memories and root-sum-square path.
	logic [15:0] mem_y [0:BUF_DEPTH-1];
	logic [15:0] mem_z [0:BUF_DEPTH-1];
	logic [15:0] mem_rd_y, mem_rd_z, y_sel, z_sel, z_hold, next_z_hold, y_wdata, z_wdata;
	logic [PNTR_W-1:0] wr_idx, next_wr_idx, pntr_q;
	logic y_wr, z_wr, rss_use, next_rss_use, load_pend, capture;
	logic [31:0] sq_x, sq_y, sq_z;
	logic [15:0] m_x, m_y, m_z;
	avbb_rss_if rss_bus();
	assign capture = sample_valid && stored_mode;
	// Velocity replaces acceleration when enabled; both are signed counts.
	assign y_sel = fft_mode ? spectrum_y : (vel_en ? velocity_y : accel_y);
	assign z_sel = fft_mode ? spectrum_z : (vel_en ? velocity_z : accel_z);
	assign m_x = mag(fft_mode ? spectrum_x : (vel_en ? velocity_x : accel_x), fft_mode);
	assign m_y = mag(y_sel, fft_mode);
	assign m_z = mag(z_sel, fft_mode);
	// Squares are formed at full 32-bit width so no product bits are lost.
	assign sq_x = {16'h0000, m_x} * {16'h0000, m_x};
	assign sq_y = {16'h0000, m_y} * {16'h0000, m_y};
	assign sq_z = {16'h0000, m_z} * {16'h0000, m_z};
	assign rss_bus.start = capture;
	assign rss_bus.radicand = 34'(sq_x) + 34'(sq_y) + 34'(sq_z);
	assign rss_bus.sat_unsigned = fft_mode;
	avbb_rss u_rss (
		.clk(clk),
		.rst_b(rst_b),
		.rss(rss_bus.solver)
	);
	always_comb begin
		next_wr_idx = wr_idx;
		next_z_hold = z_hold;
		next_rss_use = rss_use;
		if (capture) begin
			next_z_hold = z_sel;
			next_rss_use = rss_en;
		end
		if (rss_bus.done) begin
			next_wr_idx = wr_idx + 1'b1;
		end
		if (capture_start) begin
			next_wr_idx = '0;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_idx <= '0;
			z_hold <= 16'h0000;
			rss_use <= 1'b0;
			y_wr <= 1'b0;
			z_wr <= 1'b0;
			y_wdata <= 16'h0000;
			z_wdata <= 16'h0000;
			pntr_q <= '0;
			load_pend <= 1'b0;
		end else begin
			wr_idx <= next_wr_idx;
			z_hold <= next_z_hold;
			rss_use <= next_rss_use;
			y_wr <= capture;
			z_wr <= rss_bus.done;
			y_wdata <= y_sel;
			z_wdata <= rss_use ? rss_bus.root : z_hold;
			pntr_q <= buf_pntr;
			load_pend <= capture_done || (buf_pntr != pntr_q);
		end
	end
	always_ff @(posedge clk) begin
		if (y_wr) begin
			mem_y[wr_idx] <= y_wdata;
		end
		if (z_wr) begin
			mem_z[wr_idx - 1'b1] <= z_wdata;
		end
		mem_rd_y <= mem_y[buf_pntr];
		mem_rd_z <= mem_z[buf_pntr];
	end

	// Sample-rate divider, bias correction and autonull per axis.
	logic [DIV_W-1:0] div_cnt, next_div_cnt;
	logic tick;
	avbb_an_state_t an_state, next_an_state;
	logic [ANC_W-1:0] an_cnt, next_an_cnt;
	logic [15:0] raw [0:2];
	logic [15:0] corr [0:2];
	logic [15:0] an_bias [0:2];
	logic [15:0] flash_bias [0:2];
	assign raw[0] = raw_x;
	assign raw[1] = raw_y;
	assign raw[2] = raw_z;
	assign flash_bias[0] = flash_x_bias;
	assign flash_bias[1] = flash_y_bias;
	assign flash_bias[2] = flash_z_bias;
	assign tick = (div_cnt == DIV_W'(SAMPLE_DIV - 1));
	assign next_div_cnt = tick ? '0 : div_cnt + 1'b1;
	always_comb begin
		next_an_state = an_state;
		next_an_cnt = an_cnt;
		case (an_state)
			AVBB_AN_IDLE: begin
				if (autonull_cmd) begin
					next_an_state = AVBB_AN_ACC;
					next_an_cnt = '0;
				end
			end
			AVBB_AN_ACC: begin
				if (tick) begin
					next_an_cnt = an_cnt + 1'b1;
					if (an_cnt == ANC_W'(AN_SAMPLES - 1)) begin
						next_an_state = AVBB_AN_DONE;
					end
				end
			end
			AVBB_AN_DONE: next_an_state = AVBB_AN_IDLE;
			default: next_an_state = AVBB_AN_IDLE;
		endcase
	end
	for (genvar a = 0; a < 3; a++) begin : g_axis
		logic [ACC_W-1:0] acc, next_acc;
		logic [16:0] mean;
		assign mean = acc[AN_SHIFT +: 17];
		assign an_bias[a] = sat17(17'h0 - mean);
		always_comb begin
			next_acc = acc;
			if (an_state == AVBB_AN_IDLE) begin
				next_acc = '0;
			end else if (an_state == AVBB_AN_ACC && tick) begin
				next_acc = acc + {{(ACC_W-16){raw[a][15]}}, raw[a]};
			end
		end
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				acc <= '0;
				corr[a] <= 16'h0000;
			end else begin
				acc <= next_acc;
				if (tick) begin
					corr[a] <= sat17({raw[a][15], raw[a]} + {regs[2+a][15], regs[2+a]});
				end
			end
		end
	end
	assign corrected_x = corr[0];
	assign corrected_y = corr[1];
	assign corrected_z = corr[2];

	// Register bank: host bytes first, then loads from hardware take precedence.
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			next_regs[i] = regs[i];
		end
		next_restored = 1'b1;
		if (wr_strobe && wr_addr >= `AVBB_ADDR_Y_BUF && wr_addr <= `AVBB_ADDR_LAST) begin
			if (wr_addr[0]) begin
				next_regs[wr_off[3:1]][15:8] = word[7:0];
			end else begin
				next_regs[wr_off[3:1]][7:0] = word[7:0];
			end
		end
		if (load_pend) begin
			next_regs[0] = mem_rd_y;
			next_regs[1] = mem_rd_z;
		end
		for (int i = 0; i < 3; i++) begin
			if (an_state == AVBB_AN_DONE) begin
				next_regs[2+i] = an_bias[i];
			end
			if (!restored && flash_valid) begin
				next_regs[2+i] = flash_bias[i];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 5; i++) begin
				regs[i] <= `AVBB_RESET_WORD;
			end
			restored <= 1'b0;
			div_cnt <= '0;
			an_state <= AVBB_AN_IDLE;
			an_cnt <= '0;
			autonull_busy <= 1'b0;
		end else begin
			for (int i = 0; i < 5; i++) begin
				regs[i] <= next_regs[i];
			end
			restored <= next_restored;
			div_cnt <= next_div_cnt;
			an_state <= next_an_state;
			an_cnt <= next_an_cnt;
			autonull_busy <= (next_an_state != AVBB_AN_IDLE);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_buf_read_delivered;
		frame_start && rd_pend && rd_is_buf && stored_mode;
	endsequence
	sequence s_an_start;
		an_state == AVBB_AN_IDLE && autonull_cmd;
	endsequence
	sequence s_an_last;
		an_state == AVBB_AN_ACC && tick && an_cnt == ANC_W'(AN_SAMPLES - 1);
	endsequence
	chk_buf_read_advance: assert property (s_buf_read_delivered |=> buf_advance)
		else $error("buffer read did not advance the pointer");
	chk_stream_no_advance: assert property (buf_advance |-> $past(rec_mode) != 2'b11)
		else $error("pointer advanced in streaming mode");
	chk_reset_buf_zero: assert property ($past(!rst_b) |->
		regs[0] == 16'h0000 && regs[1] == 16'h0000)
		else $error("buffer words not zero after reset");
	chk_flash_bias_restore: assert property (!restored && flash_valid |=>
		regs[2] == $past(flash_x_bias) && regs[4] == $past(flash_z_bias))
		else $error("stored bias not restored");
	chk_bias_low_write: assert property (wr_strobe && wr_addr == `AVBB_ADDR_X_BIAS &&
		restored && an_state != AVBB_AN_DONE |=> regs[2][7:0] == $past(word[7:0]))
		else $error("bias low byte write lost");
	chk_bias_offset_add: assert property (tick &&
		raw_z[15:14] != 2'b01 && raw_z[15:14] != 2'b10 &&
		regs[4][15:14] != 2'b01 && regs[4][15:14] != 2'b10 |=>
		16'(corrected_z - $past(raw_z)) == $past(regs[4]))
		else $error("bias offset not applied");
	chk_autonull_busy: assert property (s_an_start |=> autonull_busy [*8])
		else $error("autonull not busy after command");
	chk_autonull_finish: assert property (s_an_last |=>
		an_state == AVBB_AN_DONE ##1 (!autonull_busy && regs[3] == $past(an_bias[1])))
		else $error("autonull did not update bias after last sample");
	chk_rss_latency: assert property (capture |-> ##19 z_wr)
		else $error("root-sum-square result late");
	chk_rss_full_scale: assert property (z_wr && rss_use && !$past(fft_mode, 19) |->
		z_wdata <= 16'h7fff)
		else $error("signed root-sum-square exceeds full scale");
	chk_y_format_pick: assert property (capture && fft_mode |=> y_wdata == $past(spectrum_y))
		else $error("spectrum word not stored unsigned");
	chk_velocity_pick: assert property (capture && !fft_mode && vel_en |=> y_wdata == $past(velocity_y))
		else $error("velocity not stored in place of acceleration");
endmodule

// ### avbb_host.sv
// Purpose: Host model that frames 16-bit words on the serial port of the bank.
// Assumes: Serial clock idles high; four module clocks per serial clock phase.
// Notes: Data in has no pull, so it shows the inverse of its last bit between frames.
module avbb_host (
	input wire logic clk,
	input wire logic dout,
	output logic sclk,
	output logic cs_b,
	output logic din
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sclk = 1'b1;
		cs_b = 1'b1;
		din = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Data out is taken just before each rising serial edge, when it has settled.
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_b = 1'b0;
		tick(2);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = w[i];
			tick(4);
			r[i] = dout;
			sclk = 1'b1;
			tick(4);
		end
		tick(1);
		cs_b = 1'b1;
		din = ~din;
		tick(4);
	endtask

	task automatic write_word(input logic [6:0] a, input logic [15:0] v);
		logic [15:0] r;
		xfer({1'b1, a, v[7:0]}, r);
		xfer({1'b1, a | 7'h01, v[15:8]}, r);
	endtask

	// The answer to a read comes back in the following frame.
	task automatic read_word(input logic [6:0] a, output logic [15:0] v);
		xfer({1'b0, a, 8'h00}, v);
		xfer(16'h0000, v);
	endtask
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the axis buffer and bias bank.
// Assumes: Short autonull and tick counts set through the top parameters.
// Notes: Sample sources not selected by the mode carry a filler so a wrong pick shows.
`include "avbb_params.svh"
module tb_top import avbb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst_b, sclk, cs_b, din, dout, rss_en, vel_en, autonull_cmd, flash_valid;
	logic [1:0] rec_mode;
	logic capture_start, capture_done, sample_valid, buf_advance, autonull_busy;
	logic [15:0] flash_x_bias, flash_y_bias, flash_z_bias, raw_x, raw_y, raw_z;
	logic [15:0] accel_x, accel_y, accel_z, velocity_x, velocity_y, velocity_z;
	logic [15:0] spectrum_x, spectrum_y, spectrum_z, corrected_x, corrected_y, corrected_z;
	logic [5:0] buf_pntr;
	logic [15:0] rd;
	int fail_count = 0;
	int n_compared = 0;
	int adv_count = 0;
	int adv_mark;

	`define CHK(what, exp, got) check(what, exp, got)

	avbb_top #(.BUF_DEPTH(64), .PNTR_W(6), .AN_SAMPLES(16), .AN_SHIFT(4), .SAMPLE_DIV(4))
	i_avbb_top (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout),
		.rec_mode(rec_mode), .rss_en(rss_en), .vel_en(vel_en), .autonull_cmd(autonull_cmd),
		.flash_valid(flash_valid), .flash_x_bias(flash_x_bias), .flash_y_bias(flash_y_bias),
		.flash_z_bias(flash_z_bias), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
		.capture_start(capture_start), .capture_done(capture_done),
		.sample_valid(sample_valid), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
		.velocity_x(velocity_x), .velocity_y(velocity_y), .velocity_z(velocity_z),
		.spectrum_x(spectrum_x), .spectrum_y(spectrum_y), .spectrum_z(spectrum_z),
		.buf_pntr(buf_pntr), .buf_advance(buf_advance), .corrected_x(corrected_x),
		.corrected_y(corrected_y), .corrected_z(corrected_z), .autonull_busy(autonull_busy));

	avbb_host i_avbb_host (.clk(clk), .dout(dout), .sclk(sclk), .cs_b(cs_b), .din(din));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (buf_advance === 1'b1) begin
			adv_count++;
		end
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic do_reset();
		rst_b = 1'b0;
		cyc(16);
		rst_b = 1'b1;
		cyc(3);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask

	task automatic run_case(input logic [1:0] m, input logic v, input logic r,
		input logic [15:0] x, input logic [15:0] y, input logic [15:0] z,
		input logic [15:0] ey, input logic [15:0] ez);
		rec_mode = m;
		vel_en = v;
		rss_en = r;
		{accel_x, accel_y, accel_z} = {3{16'h5a5a}};
		{velocity_x, velocity_y, velocity_z} = {3{16'h5a5a}};
		{spectrum_x, spectrum_y, spectrum_z} = {3{16'h5a5a}};
		if (!m[1]) begin
			{spectrum_x, spectrum_y, spectrum_z} = {x, y, z};
		end else if (v) begin
			{velocity_x, velocity_y, velocity_z} = {x, y, z};
		end else begin
			{accel_x, accel_y, accel_z} = {x, y, z};
		end
		pulse(capture_start);
		pulse(sample_valid);
		cyc(25);
		pulse(capture_done);
		cyc(5);
		adv_mark = adv_count;
		i_avbb_host.read_word(`AVBB_ADDR_Y_BUF, rd);
		`CHK("y buffer", ey, rd);
		i_avbb_host.read_word(`AVBB_ADDR_Z_BUF, rd);
		`CHK("z buffer", ez, rd);
		`CHK("pointer advances", 16'(adv_mark + 2), 16'(adv_count));
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		// The whole sequence needs under ten thousand cycles; twice that means a hang.
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end

	initial begin
		{rst_b, rss_en, vel_en, autonull_cmd, flash_valid} = 5'h00;
		{capture_start, capture_done, sample_valid} = 3'h0;
		rec_mode = 2'b11;
		{flash_x_bias, flash_y_bias, flash_z_bias} = {16'h1111, 16'heeee, 16'h0123};
		{raw_x, raw_y, raw_z} = {16'h0100, 16'h8000, 16'h0300};
		{accel_x, accel_y, accel_z, velocity_x, velocity_y, velocity_z} = '0;
		{spectrum_x, spectrum_y, spectrum_z} = '0;
		buf_pntr = 6'h00;
		do_reset();
		for (int i = 0; i < 5; i++) begin
			i_avbb_host.read_word(`AVBB_ADDR_Y_BUF + 7'(2 * i), rd);
			`CHK("reset word", 16'h0000, rd);
		end
		`CHK("no advance in streaming", 16'h0000, 16'(adv_count));
		i_avbb_host.write_word(`AVBB_ADDR_X_BIAS, 16'h0064);
		i_avbb_host.write_word(`AVBB_ADDR_Y_BIAS, 16'hff9c);
		i_avbb_host.write_word(`AVBB_ADDR_Z_BIAS, 16'hfdde);
		i_avbb_host.write_word(7'h1a, 16'hffff);
		i_avbb_host.read_word(`AVBB_ADDR_X_BIAS, rd);
		`CHK("x bias", 16'h0064, rd);
		i_avbb_host.read_word(`AVBB_ADDR_Y_BIAS, rd);
		`CHK("y bias", 16'hff9c, rd);
		i_avbb_host.read_word(`AVBB_ADDR_Z_BIAS, rd);
		`CHK("z bias", 16'hfdde, rd);
		i_avbb_host.read_word(7'h1a, rd);
		`CHK("unmapped", 16'h0000, rd);
		cyc(10);
		`CHK("x corrected", 16'h0164, corrected_x);
		`CHK("y corrected", 16'h8000, corrected_y);
		`CHK("z corrected", 16'h00de, corrected_z);
		run_case(2'b00, 1'b0, 1'b0, 16'h0000, 16'hf000, 16'h1000, 16'hf000, 16'h1000);
		run_case(2'b01, 1'b0, 1'b1, 16'hc000, 16'hc000, 16'hc000, 16'hc000, 16'hffff);
		run_case(2'b10, 1'b1, 1'b0, 16'h0000, 16'h99a8, 16'h7fff, 16'h99a8, 16'h7fff);
		run_case(2'b10, 1'b0, 1'b1, 16'h0003, 16'h0004, 16'h000c, 16'h0004, 16'h000d);
		run_case(2'b10, 1'b0, 1'b1, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h7fff);
		{raw_x, raw_y, raw_z} = {16'h0010, 16'hfff0, 16'h0000};
		pulse(autonull_cmd);
		`CHK("autonull busy", 16'h0001, 16'(autonull_busy));
		for (int i = 0; i < 400 && autonull_busy !== 1'b0; i++) begin
			cyc(1);
		end
		`CHK("autonull done", 16'h0000, 16'(autonull_busy));
		i_avbb_host.read_word(`AVBB_ADDR_X_BIAS, rd);
		`CHK("x null", 16'hfff0, rd);
		i_avbb_host.read_word(`AVBB_ADDR_Y_BIAS, rd);
		`CHK("y null", 16'h0010, rd);
		i_avbb_host.read_word(`AVBB_ADDR_Z_BIAS, rd);
		`CHK("z null", 16'h0000, rd);
		`CHK("x nulled output", 16'h0000, corrected_x);
		flash_valid = 1'b1;
		do_reset();
		i_avbb_host.read_word(`AVBB_ADDR_X_BIAS, rd);
		`CHK("x restored", 16'h1111, rd);
		i_avbb_host.read_word(`AVBB_ADDR_Y_BIAS, rd);
		`CHK("y restored", 16'heeee, rd);
		i_avbb_host.read_word(`AVBB_ADDR_Z_BIAS, rd);
		`CHK("z restored", 16'h0123, rd);
		complete_run();
	end
endmodule
